// >>> design/spl_consts.svh
`ifndef SPL_CONSTS_SVH
`define SPL_CONSTS_SVH

// strap bit positions in the latched word
`define SPL_BIT_LDO       0
`define SPL_BIT_BOOT      1
`define SPL_BIT_DLQ       2
`define SPL_BIT_LOG       3
`define SPL_BIT_SDIO      4
`define SPL_NUM_STRAPS    5
// weak pull defaults, 1 = pull-up
`define SPL_PULL_DEFAULT  5'h1_A
`define SPL_LATCH_RESET   5'h1_A

`endif

// >>> design/spl_pkg.sv
`default_nettype none
package spl_pkg;
    typedef enum logic [1:0] {
        SPL_BOOT_FLASH    = 2'h0,
        SPL_BOOT_DOWNLOAD = 2'h1,
        SPL_BOOT_INVALID  = 2'h2
    } spl_boot_type;

    typedef enum logic [1:0] {
        SPL_ST_RESET = 2'h0,
        SPL_ST_RUN   = 2'h1
    } spl_state_type;
endpackage
`default_nettype wire

// >>> design/spl_strap_latch.sv
// Contract
// - On each system reset the five strap pin levels are sampled into the latch.
// - The latched bits hold unchanged until the next system reset, ignoring later pin activity.
// - The five latched bits are readable by software as a status word.
// - During reset a weak pull on each strap pin sets its default level.
// - After reset the strap pins are released to their normal functions.
// - The flash-supply regulator runs at 3.3 V on a latched 0 and 1.8 V on a latched 1.
// - Boot-select 1 gives flash boot; boot-select 0 with download-qualify 0 gives download boot.
// - SDIO slave input and output edges follow the code {log strap, sdio edge strap}.
// - Firmware may override the strapped regulator voltage and SDIO edge timing.
// - Software can switch off the flash-supply regulator.
`timescale 1ns/100ps
`default_nettype none
`include "spl_consts.svh"

module spl_strap_latch #(
    parameter int NUM_STRAPS = `SPL_NUM_STRAPS
) (
    input  wire logic       I_CORE_CLK,
    input  wire logic       I_RST_N,
    input  wire logic       i_sys_reset,
    input  wire logic [4:0] i_strap_pins,
    input  wire logic       i_ovr_ldo_en,
    input  wire logic       i_ovr_ldo_1v8,
    input  wire logic       i_ovr_sdio_en,
    input  wire logic [1:0] i_ovr_sdio_code,
    input  wire logic       i_ldo_off,
    output logic [4:0]      o_strap_status,
    output logic [4:0]      o_pull_en,
    output logic [4:0]      o_pull_up,
    output logic            o_straps_released,
    output logic            o_ldo_enable,
    output logic            o_ldo_1v8,
    output logic [1:0]      o_boot_mode,
    output logic            o_boot_log_en,
    output logic            o_sdio_in_rising,
    output logic            o_sdio_out_rising
);

    // latch width is fixed at five straps
    if (NUM_STRAPS != `SPL_NUM_STRAPS) begin : g_bad_strap_count
        $error("strap count must be five");
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [4:0] pin_meta_reg;
    logic [4:0] pin_sync_reg;
    logic       rst_meta_reg;
    logic       rst_sync_reg;

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            pin_meta_reg <= 5'h0_0;
            pin_sync_reg <= 5'h0_0;
        end else begin
            pin_meta_reg <= i_strap_pins;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= 1'b1;
        end else begin
            rst_meta_reg <= i_sys_reset;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reset phase tracking
    spl_pkg::spl_state_type state_reg;

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state_reg <= spl_pkg::SPL_ST_RESET;
        end else begin
            unique case (state_reg)
                spl_pkg::SPL_ST_RESET: begin
                    if (!rst_sync_reg) begin
                        state_reg <= spl_pkg::SPL_ST_RUN;
                    end
                end
                spl_pkg::SPL_ST_RUN: begin
                    if (rst_sync_reg) begin
                        state_reg <= spl_pkg::SPL_ST_RESET;
                    end
                end
                default: begin
                    state_reg <= spl_pkg::SPL_ST_RESET;
                end
            endcase
        end
    end

    wire logic in_reset = (state_reg == spl_pkg::SPL_ST_RESET);

    assign o_pull_en = in_reset ? 5'h1_F : 5'h0_0;
    assign o_pull_up = `SPL_PULL_DEFAULT;
    assign o_straps_released = !in_reset;

    ////////////////////////////////////////////////////////////////////////
    // strap latch
    logic [4:0] latch_reg;

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            latch_reg <= `SPL_LATCH_RESET;
        end else if (in_reset) begin
            latch_reg <= pin_sync_reg;
        end
    end

    assign o_strap_status = latch_reg;

    ////////////////////////////////////////////////////////////////////////
    // decoded settings
    logic       ldo_en_reg;
    logic       ldo_1v8_reg;
    logic [1:0] boot_reg;
    logic       log_reg;
    logic [1:0] sdio_reg;

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            ldo_en_reg  <= 1'b1;
            ldo_1v8_reg <= 1'b0;
        end else begin
            ldo_en_reg  <= !i_ldo_off;
            ldo_1v8_reg <= (i_ovr_ldo_en && !in_reset) ? i_ovr_ldo_1v8 : latch_reg[`SPL_BIT_LDO];
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            boot_reg <= spl_pkg::SPL_BOOT_FLASH;
        end else if (latch_reg[`SPL_BIT_BOOT]) begin
            boot_reg <= spl_pkg::SPL_BOOT_FLASH;
        end else if (!latch_reg[`SPL_BIT_DLQ]) begin
            boot_reg <= spl_pkg::SPL_BOOT_DOWNLOAD;
        end else begin
            boot_reg <= spl_pkg::SPL_BOOT_INVALID;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            log_reg  <= 1'b0;
            sdio_reg <= 2'h3;
        end else begin
            log_reg  <= !latch_reg[`SPL_BIT_LOG];
            sdio_reg <= (i_ovr_sdio_en && !in_reset) ? i_ovr_sdio_code
                        : {latch_reg[`SPL_BIT_LOG], latch_reg[`SPL_BIT_SDIO]};
        end
    end

    assign o_ldo_enable      = ldo_en_reg;
    assign o_ldo_1v8         = ldo_1v8_reg;
    assign o_boot_mode       = boot_reg;
    assign o_boot_log_en     = log_reg;
    assign o_sdio_in_rising  = sdio_reg[1];
    assign o_sdio_out_rising = sdio_reg[0];

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_hold;
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        !in_reset && !rst_sync_reg |=> $stable(latch_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("latch changed after reset");

    property p_sample;
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        in_reset |=> latch_reg == $past(pin_sync_reg);
    endproperty
    a_sample: assert property (p_sample) else $error("latch missed sample");

    property p_pull;
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        o_pull_en == (in_reset ? 5'h1_F : 5'h0_0) && o_straps_released == !in_reset;
    endproperty
    a_pull: assert property (p_pull) else $error("pull state wrong");

    property p_ldo;
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        !i_ovr_ldo_en |=> o_ldo_1v8 == $past(latch_reg[`SPL_BIT_LDO]);
    endproperty
    a_ldo: assert property (p_ldo) else $error("ldo voltage wrong");

    property p_boot;
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        latch_reg[`SPL_BIT_BOOT] |=> o_boot_mode == spl_pkg::SPL_BOOT_FLASH;
    endproperty
    a_boot: assert property (p_boot) else $error("boot mode wrong");

    property p_dl;
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        !latch_reg[`SPL_BIT_BOOT] && !latch_reg[`SPL_BIT_DLQ] |=> o_boot_mode == spl_pkg::SPL_BOOT_DOWNLOAD;
    endproperty
    a_dl: assert property (p_dl) else $error("download mode wrong");

    property p_log;
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        1'b1 |=> o_boot_log_en == !$past(latch_reg[`SPL_BIT_LOG]);
    endproperty
    a_log: assert property (p_log) else $error("log enable wrong");

    property p_sdio;
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        !i_ovr_sdio_en |=> {o_sdio_in_rising, o_sdio_out_rising} == $past({latch_reg[3], latch_reg[4]});
    endproperty
    a_sdio: assert property (p_sdio) else $error("sdio timing wrong");

    property p_ovr;
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        i_ovr_sdio_en && !in_reset |=> {o_sdio_in_rising, o_sdio_out_rising} == $past(i_ovr_sdio_code);
    endproperty
    a_ovr: assert property (p_ovr) else $error("sdio override ignored");

    property p_off;
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        i_ldo_off |=> !o_ldo_enable;
    endproperty
    a_off: assert property (p_off) else $error("ldo not off");

    // status shows the last pin sample taken before release
    property p_stat;
        @(posedge I_CORE_CLK) disable iff (!I_RST_N)
        $fell(in_reset) |-> o_strap_status == $past(pin_sync_reg);
    endproperty
    a_stat: assert property (p_stat) else $error("status mismatch");

endmodule
`default_nettype wire

// >>> sim/spl_board_model.sv
`timescale 1ns/100ps
`default_nettype none
module spl_board_model #(
    parameter bit EMBEDDED_FLASH = 1'b0
) (
    input  wire logic       i_clk,
    input  wire logic       i_drive,
    input  wire logic [4:0] i_level,
    input  wire logic [4:0] i_pull_en,
    input  wire logic [4:0] i_pull_up,
    output logic [4:0]      o_pins
);
    logic [4:0] last_reg;
    always_ff @(posedge i_clk) begin
        last_reg <= o_pins;
    end
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            if (i_drive) begin
                o_pins[i] = i_level[i];
            end else if (i_pull_en[i]) begin
                o_pins[i] = i_pull_up[i];
            end else begin
                o_pins[i] = ~last_reg[i];
            end
        end
        if (EMBEDDED_FLASH) begin
            o_pins[0] = 1'b1;
        end
    end
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; $display("[ERR] %0t mismatch", $time); end end
module tb_top;
    logic        clk, rst_n, sys_rst, drv, ovr_l, ovr_v, ovr_s, ldo_off;
    logic [4:0]  lvl, pins, st, pen, pup;
    logic [1:0]  ovr_c, boot;
    logic        rel, ldo_en, v18, log_en, sin, sout;
    logic [31:0] seed;
    int          err_count, compares;
    logic [4:0]  corner [6] = '{5'h00, 5'h1F, 5'h04, 5'h08, 5'h10, 5'h02};

    spl_board_model u_spl_board_model (.i_clk(clk), .i_drive(drv), .i_level(lvl),
        .i_pull_en(pen), .i_pull_up(pup), .o_pins(pins));
    spl_strap_latch u_spl_strap_latch (.I_CORE_CLK(clk), .I_RST_N(rst_n), .i_sys_reset(sys_rst),
        .i_strap_pins(pins), .i_ovr_ldo_en(ovr_l), .i_ovr_ldo_1v8(ovr_v), .i_ovr_sdio_en(ovr_s),
        .i_ovr_sdio_code(ovr_c), .i_ldo_off(ldo_off), .o_strap_status(st), .o_pull_en(pen),
        .o_pull_up(pup), .o_straps_released(rel), .o_ldo_enable(ldo_en), .o_ldo_1v8(v18),
        .o_boot_mode(boot), .o_boot_log_en(log_en), .o_sdio_in_rising(sin), .o_sdio_out_rising(sout));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    function automatic logic [1:0] exp_boot(input logic [4:0] p);
        return p[1] ? spl_pkg::SPL_BOOT_FLASH : (p[2] ? spl_pkg::SPL_BOOT_INVALID : spl_pkg::SPL_BOOT_DOWNLOAD);
    endfunction

    task automatic results;
        $display("counts: err_count=%0d compares=%0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic boot_cycle(input logic d, input logic [4:0] v);
        logic [4:0] e;
        int         n;
        e = d ? v : 5'h1A;
        @(negedge clk);
        sys_rst = 1'b1;
        drv = d;
        lvl = v;
        repeat (4) @(negedge clk);
        `CHK(pen, 5'h1F)
        `CHK(pup, 5'h1A)
        sys_rst = 1'b0;
        n = 0;
        while (rel !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        if (n == 20) begin
            err_count++;
            results();
        end
        repeat (2) @(negedge clk);
        `CHK(st, e)
        `CHK(pen, 5'h00)
        `CHK(v18, e[0])
        `CHK(boot, exp_boot(e))
        `CHK(log_en, ~e[3])
        `CHK({sin, sout}, {e[3], e[4]})
        `CHK(ldo_en, 1'b1)
        drv = 1'b1;
        lvl = ~e;
        repeat (4) @(negedge clk);
        `CHK(st, e)
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        rst_n = 1'b0;
        sys_rst = 1'b1;
        drv = 1'b0;
        lvl = 5'h00;
        {ovr_l, ovr_v, ovr_s, ldo_off} = 4'h0;
        ovr_c = 2'h0;
        seed = 32'd55701;
        err_count = 0;
        compares = 0;
        repeat (20) @(negedge clk);
        `CHK(st, 5'h1A)
        rst_n = 1'b1;
        repeat (25000) @(negedge clk);
        boot_cycle(1'b0, 5'h00);
        foreach (corner[i]) begin
            boot_cycle(1'b1, corner[i]);
        end
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            boot_cycle(1'b1, seed[4:0]);
        end
        for (int k = 0; k < 4; k++) begin
            ovr_l = 1'b1;
            ovr_s = 1'b1;
            ovr_v = k[0];
            ovr_c = k[1:0];
            ldo_off = k[1];
            repeat (3) @(negedge clk);
            if (!ldo_off) `CHK(v18, ovr_v)
            `CHK({sin, sout}, ovr_c)
            `CHK(ldo_en, ~ldo_off)
        end
        seed = xs(seed);
        lvl = seed[4:0];
        sys_rst = 1'b1;
        ovr_v = ~lvl[0];
        ovr_c = ~{lvl[3], lvl[4]};
        repeat (6) @(negedge clk);
        `CHK(v18, lvl[0])
        `CHK({sin, sout}, {lvl[3], lvl[4]})
        results();
    end
endmodule
`default_nettype wire
